// ### verilog/gate_term_pkg.sv
// shared constants, types and register map of the gate term select stage
package gate_term_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned OFFSET_W    = 8;
    localparam int unsigned SRC_SEL_W   = 6;
    localparam int unsigned SRC_COUNT   = 64;
    localparam int unsigned TERM_W      = 8;
    localparam int unsigned INPUT_COUNT = 4;

    // ****************************************************************
    // register offsets (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [OFFSET_W-1:0] ADDR_DATA1_SEL  = 8'h00;
    localparam logic [OFFSET_W-1:0] ADDR_DATA2_SEL  = 8'h04;
    localparam logic [OFFSET_W-1:0] ADDR_DATA3_SEL  = 8'h08;
    localparam logic [OFFSET_W-1:0] ADDR_DATA4_SEL  = 8'h0C;
    localparam logic [OFFSET_W-1:0] ADDR_GATE2_TERM = 8'h10;
    localparam logic [OFFSET_W-1:0] ADDR_GATE3_TERM = 8'h14;
    localparam logic [OFFSET_W-1:0] ADDR_STATUS     = 8'h18;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [SRC_SEL_W-1:0] SRC_SEL_RESET = 6'h00;
    localparam logic [TERM_W-1:0]    TERM_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]    RDATA_RESET   = 32'h0000_0000;

    // ****************************************************************
    // bus encodings
    // ****************************************************************
    localparam int unsigned  HTRANS_ACTIVE_BIT = 1;
    localparam logic         HRESP_OKAY        = 1'b0;

    // ****************************************************************
    // types
    // ****************************************************************
    // bit 7 down to bit 0 of a term select register
    typedef struct packed {
        logic d4True;
        logic d4Inv;
        logic d3True;
        logic d3Inv;
        logic d2True;
        logic d2Inv;
        logic d1True;
        logic d1Inv;
    } termSelect_t;

    typedef struct packed {
        logic d4;
        logic d3;
        logic d2;
        logic d1;
    } dataInputs_t;

    // status: bit 5 gate3, bit 4 gate2, bits 3..0 data inputs 4..1
    typedef struct packed {
        logic gate3;
        logic gate2;
    } gateTerms_t;

    typedef enum logic [2:0] {
        REG_DATA1_SEL,
        REG_DATA2_SEL,
        REG_DATA3_SEL,
        REG_DATA4_SEL,
        REG_GATE2_TERM,
        REG_GATE3_TERM,
        REG_STATUS,
        REG_NONE
    } regId_t;

endpackage : gate_term_pkg

// ### verilog/source_select_stage.sv
// one data input source multiplexer with registered output
module source_select_stage (
    input  wire logic                                 core_clk,
    input  wire logic                                 rst,
    input  wire logic                                 clkEn,
    input  wire logic [gate_term_pkg::SRC_COUNT-1:0]  sources,
    input  wire logic [gate_term_pkg::SRC_SEL_W-1:0]  select,
    output logic                                      picked
);

    // registered so the gate stage never sees a mux glitch on select change
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            picked <= 1'b0;
        end else if (clkEn) begin
            picked <= sources[select];
        end
    end

endmodule : source_select_stage

// ### verilog/gate_term_select.sv
// gate 2 and gate 3 term selection with AHB-Lite register access
//
// What this block does
// - gate 2 takes data input 4 true when its bit 7 is set and inverted when its bit 6 is set.
// - gate 2 takes data input 3 true when its bit 5 is set and inverted when its bit 4 is set.
// - gate 2 takes data input 2 true when its bit 3 is set and inverted when its bit 2 is set.
// - gate 2 takes data input 1 true when its bit 1 is set and inverted when its bit 0 is set.
// - gate 3 takes data input 4 true when its bit 7 is set and inverted when its bit 6 is set.
// - gate 3 takes data input 3 true when its bit 5 is set and inverted when its bit 4 is set.
// - gate 3 takes data input 2 true when its bit 3 is set and inverted when its bit 2 is set.
// - gate 3 takes data input 1 true when its bit 1 is set and inverted when its bit 0 is set.
// - a cleared select bit leaves that polarity out, whatever its companion bit says.
// - every select bit reads and writes, and only the power-on reset touches it.
// - each of the four data inputs comes from its own source mux steered by a 6-bit field.
module gate_term_select (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    input  wire logic                                  clkEn,
    input  wire logic                                  hsel,
    input  wire logic [gate_term_pkg::ADDR_W-1:0]      haddr,
    input  wire logic [1:0]                            htrans,
    input  wire logic                                  hwrite,
    input  wire logic [2:0]                            hsize,
    input  wire logic [gate_term_pkg::DATA_W-1:0]      hwdata,
    input  wire logic                                  hready,
    output logic                                       hreadyout,
    output logic                                       hresp,
    output logic [gate_term_pkg::DATA_W-1:0]           hrdata,
    input  wire logic [gate_term_pkg::SRC_COUNT-1:0]   sourcePins,
    output gate_term_pkg::dataInputs_t                 dataInputs,
    output gate_term_pkg::gateTerms_t                  gateTerms
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic gate_term_pkg::regId_t decodeReg(
        input logic [gate_term_pkg::OFFSET_W-1:0] offset
    );
        gate_term_pkg::regId_t id;
        unique case (offset)
            gate_term_pkg::ADDR_DATA1_SEL:  id = gate_term_pkg::REG_DATA1_SEL;
            gate_term_pkg::ADDR_DATA2_SEL:  id = gate_term_pkg::REG_DATA2_SEL;
            gate_term_pkg::ADDR_DATA3_SEL:  id = gate_term_pkg::REG_DATA3_SEL;
            gate_term_pkg::ADDR_DATA4_SEL:  id = gate_term_pkg::REG_DATA4_SEL;
            gate_term_pkg::ADDR_GATE2_TERM: id = gate_term_pkg::REG_GATE2_TERM;
            gate_term_pkg::ADDR_GATE3_TERM: id = gate_term_pkg::REG_GATE3_TERM;
            gate_term_pkg::ADDR_STATUS:     id = gate_term_pkg::REG_STATUS;
            default:                        id = gate_term_pkg::REG_NONE;
        endcase
        return id;
    endfunction : decodeReg

    // an unset enable masks its term to zero, so each polarity stands alone
    function automatic logic termOr(
        input gate_term_pkg::dataInputs_t d,
        input gate_term_pkg::termSelect_t s
    );
        logic acc;
        acc = 1'b0;
        acc = acc | (s.d4True & d.d4);
        acc = acc | (s.d4Inv  & ~d.d4);
        acc = acc | (s.d3True & d.d3);
        acc = acc | (s.d3Inv  & ~d.d3);
        acc = acc | (s.d2True & d.d2);
        acc = acc | (s.d2Inv  & ~d.d2);
        acc = acc | (s.d1True & d.d1);
        acc = acc | (s.d1Inv  & ~d.d1);
        return acc;
    endfunction : termOr

    // a pending write lands only on an enabled edge, in the register it decoded to
    function automatic logic writeHits(
        input logic                  commit,
        input gate_term_pkg::regId_t target,
        input gate_term_pkg::regId_t id
    );
        return commit && (target == id);
    endfunction : writeHits

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [gate_term_pkg::SRC_SEL_W-1:0] data1Select;
    logic [gate_term_pkg::SRC_SEL_W-1:0] data2Select;
    logic [gate_term_pkg::SRC_SEL_W-1:0] data3Select;
    logic [gate_term_pkg::SRC_SEL_W-1:0] data4Select;
    gate_term_pkg::termSelect_t          gate2TermSelect;
    gate_term_pkg::termSelect_t          gate3TermSelect;

    logic [gate_term_pkg::SRC_COUNT-1:0] pinSyncFirst;
    logic [gate_term_pkg::SRC_COUNT-1:0] pinSync;

    logic                                addrTaken;
    gate_term_pkg::regId_t               addrReg;
    logic                                wrPending;
    gate_term_pkg::regId_t               wrReg;
    logic                                wrCommit;
    logic [gate_term_pkg::DATA_W-1:0]    next_hrdata;

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinSyncFirst <= '0;
        end else if (clkEn) begin
            pinSyncFirst <= sourcePins;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinSync <= '0;
        end else if (clkEn) begin
            pinSync <= pinSyncFirst;
        end
    end

    // ****************************************************************
    // data input source multiplexers
    // ****************************************************************
    source_select_stage data1Mux (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .sources  (pinSync),
        .select   (data1Select),
        .picked   (dataInputs.d1)
    );

    source_select_stage data2Mux (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .sources  (pinSync),
        .select   (data2Select),
        .picked   (dataInputs.d2)
    );

    source_select_stage data3Mux (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .sources  (pinSync),
        .select   (data3Select),
        .picked   (dataInputs.d3)
    );

    source_select_stage data4Mux (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .sources  (pinSync),
        .select   (data4Select),
        .picked   (dataInputs.d4)
    );

    // ****************************************************************
    // gate term combining
    // ****************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gateTerms <= '0;
        end else if (clkEn) begin
            gateTerms.gate2 <= termOr(dataInputs, gate2TermSelect);
            gateTerms.gate3 <= termOr(dataInputs, gate3TermSelect);
        end
    end

    // ****************************************************************
    // bus address phase
    // ****************************************************************
    assign addrTaken = clkEn & hsel & hready & htrans[gate_term_pkg::HTRANS_ACTIVE_BIT];
    assign addrReg   = decodeReg(haddr[gate_term_pkg::OFFSET_W-1:0]);
    assign wrCommit  = clkEn & wrPending;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPending <= 1'b0;
            wrReg     <= gate_term_pkg::REG_NONE;
        end else if (clkEn) begin
            wrPending <= addrTaken & hwrite;
            wrReg     <= addrReg;
        end
    end

    // stall only while frozen; one cycle late, so a write whose data phase ends on a
    // frozen edge commits at the next enabled edge with whatever hwdata then holds
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= clkEn;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hresp <= gate_term_pkg::HRESP_OKAY;
        end else begin
            hresp <= gate_term_pkg::HRESP_OKAY;
        end
    end

    // ****************************************************************
    // source select registers
    // ****************************************************************
    // only the power-on reset reaches these; no other reset source exists here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data1Select <= gate_term_pkg::SRC_SEL_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_DATA1_SEL)) begin
            data1Select <= hwdata[gate_term_pkg::SRC_SEL_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data2Select <= gate_term_pkg::SRC_SEL_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_DATA2_SEL)) begin
            data2Select <= hwdata[gate_term_pkg::SRC_SEL_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data3Select <= gate_term_pkg::SRC_SEL_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_DATA3_SEL)) begin
            data3Select <= hwdata[gate_term_pkg::SRC_SEL_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data4Select <= gate_term_pkg::SRC_SEL_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_DATA4_SEL)) begin
            data4Select <= hwdata[gate_term_pkg::SRC_SEL_W-1:0];
        end
    end

    // ****************************************************************
    // term select registers
    // ****************************************************************
    // cleared at power-on rather than left unknown, so both gates start quiet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate2TermSelect <= gate_term_pkg::TERM_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_GATE2_TERM)) begin
            gate2TermSelect <= hwdata[gate_term_pkg::TERM_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate3TermSelect <= gate_term_pkg::TERM_RESET;
        end else if (writeHits(wrCommit, wrReg, gate_term_pkg::REG_GATE3_TERM)) begin
            gate3TermSelect <= hwdata[gate_term_pkg::TERM_W-1:0];
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    // a write committing at this edge is forwarded so back-to-back read sees it
    always_comb begin
        next_hrdata = gate_term_pkg::RDATA_RESET;
        if (wrCommit && (wrReg == addrReg)) begin
            unique case (addrReg)
                gate_term_pkg::REG_DATA1_SEL,
                gate_term_pkg::REG_DATA2_SEL,
                gate_term_pkg::REG_DATA3_SEL,
                gate_term_pkg::REG_DATA4_SEL:  next_hrdata = 32'(hwdata[gate_term_pkg::SRC_SEL_W-1:0]);
                gate_term_pkg::REG_GATE2_TERM,
                gate_term_pkg::REG_GATE3_TERM: next_hrdata = 32'(hwdata[gate_term_pkg::TERM_W-1:0]);
                gate_term_pkg::REG_STATUS:     next_hrdata = 32'({gateTerms, dataInputs});
                gate_term_pkg::REG_NONE:       next_hrdata = gate_term_pkg::RDATA_RESET;
            endcase
        end else begin
            unique case (addrReg)
                gate_term_pkg::REG_DATA1_SEL:  next_hrdata = 32'(data1Select);
                gate_term_pkg::REG_DATA2_SEL:  next_hrdata = 32'(data2Select);
                gate_term_pkg::REG_DATA3_SEL:  next_hrdata = 32'(data3Select);
                gate_term_pkg::REG_DATA4_SEL:  next_hrdata = 32'(data4Select);
                gate_term_pkg::REG_GATE2_TERM: next_hrdata = 32'(gate2TermSelect);
                gate_term_pkg::REG_GATE3_TERM: next_hrdata = 32'(gate3TermSelect);
                gate_term_pkg::REG_STATUS:     next_hrdata = 32'({gateTerms, dataInputs});
                gate_term_pkg::REG_NONE:       next_hrdata = gate_term_pkg::RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= gate_term_pkg::RDATA_RESET;
        end else if (addrTaken && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

endmodule : gate_term_select

// ### test/gate_term_select_properties.sv
// concurrent checks on the ports of the gate term select stage
module gate_term_select_props (
    input wire logic                                core_clk,
    input wire logic                                rst,
    input wire logic                                clkEn,
    input wire logic                                hsel,
    input wire logic [gate_term_pkg::ADDR_W-1:0]    haddr,
    input wire logic [1:0]                          htrans,
    input wire logic                                hwrite,
    input wire logic [2:0]                          hsize,
    input wire logic [gate_term_pkg::DATA_W-1:0]    hwdata,
    input wire logic                                hready,
    input wire logic                                hreadyout,
    input wire logic                                hresp,
    input wire logic [gate_term_pkg::DATA_W-1:0]    hrdata,
    input wire logic [gate_term_pkg::SRC_COUNT-1:0] sourcePins,
    input wire gate_term_pkg::dataInputs_t          dataInputs,
    input wire gate_term_pkg::gateTerms_t           gateTerms
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // shadow of the registers, rebuilt from bus writes
    // ****************************************************************
    logic        take;
    logic        rd;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [7:0]  term2;
    logic [7:0]  term3;
    logic [5:0]  sel [4];
    logic [63:0] pinsQ1;
    logic [63:0] pinsQ2;
    logic [3:0]  expIn;
    logic [1:0]  expGate;

    function automatic logic termOr(input logic [7:0] s, input logic [3:0] d);
        return |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction : termOr

    assign take    = clkEn && hsel && hready && htrans[gate_term_pkg::HTRANS_ACTIVE_BIT];
    assign rd      = take && !hwrite;
    // two flops mirror the pin synchroniser
    assign expIn   = {pinsQ2[sel[3]], pinsQ2[sel[2]], pinsQ2[sel[1]], pinsQ2[sel[0]]};
    assign expGate = {termOr(term3, dataInputs), termOr(term2, dataInputs)};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (clkEn) begin
            wrPend <= take && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // a pending write waits out frozen edges and lands on the next enabled one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            term2 <= 8'h00;
            term3 <= 8'h00;
            sel   <= '{default: 6'h00};
        end else if (wrPend && clkEn) begin
            case (wrAddr)
                gate_term_pkg::ADDR_GATE2_TERM: term2 <= hwdata[7:0];
                gate_term_pkg::ADDR_GATE3_TERM: term3 <= hwdata[7:0];
                default: if (wrAddr < 8'h10) sel[wrAddr[3:2]] <= hwdata[5:0];
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinsQ1 <= '0;
            pinsQ2 <= '0;
        end else if (clkEn) begin
            pinsQ1 <= sourcePins;
            pinsQ2 <= pinsQ1;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    resp_okay_a: assert property (hresp == gate_term_pkg::HRESP_OKAY)
        else $error("response other than OKAY");
    ready_follow_a: assert property (hreadyout == $past(clkEn))
        else $error("hreadyout does not follow clkEn");
    gate2_terms_a: assert property (clkEn |=> gateTerms.gate2 == $past(expGate[0]))
        else $error("gate 2 term mismatch");
    gate3_terms_a: assert property (clkEn |=> gateTerms.gate3 == $past(expGate[1]))
        else $error("gate 3 term mismatch");
    input_mux_a: assert property (clkEn |=> dataInputs == $past(expIn))
        else $error("data input source mismatch");
    term2_read_a: assert property (rd && haddr[7:0] == gate_term_pkg::ADDR_GATE2_TERM |=> hrdata == {24'h0, term2})
        else $error("gate 2 select read mismatch");
    term3_read_a: assert property (rd && haddr[7:0] == gate_term_pkg::ADDR_GATE3_TERM |=> hrdata == {24'h0, term3})
        else $error("gate 3 select read mismatch");
    unmapped_read_a: assert property (rd && haddr[7:0] > gate_term_pkg::ADDR_STATUS |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    status_read_a: assert property (rd && haddr[7:0] == gate_term_pkg::ADDR_STATUS
                                    |=> hrdata == {26'h0, $past(gateTerms), $past(dataInputs)})
        else $error("status read mismatch");
    rdata_hold_a: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    freeze_a: assert property (!clkEn |=> $stable(dataInputs) && $stable(gateTerms))
        else $error("outputs moved while disabled");
endmodule : gate_term_select_props

// ### test/gate_term_select_tb_top.sv
// self-checking bench for the gate term select stage
module gate_term_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [5:0] PICK [4] = '{6'h05, 6'h11, 6'h28, 6'h3F};

    logic                       core_clk  = 1'b0;
    logic                       rst       = 1'b1;
    logic                       clkEn     = 1'b1;
    logic                       hsel      = 1'b0;
    logic [31:0]                haddr     = 32'h0000_0000;
    logic [1:0]                 htrans    = 2'h0;
    logic                       hwrite    = 1'b0;
    logic [31:0]                hwdata    = 32'h0000_0000;
    logic [63:0]                pins      = 64'h0000_0000_0000_0000;
    logic                       hready;
    logic                       hreadyout;
    logic                       hresp;
    logic [31:0]                hrdata;
    logic [31:0]                rdVal;
    logic [7:0]                 s2;
    logic [7:0]                 s3;
    gate_term_pkg::dataInputs_t dataInputs;
    gate_term_pkg::gateTerms_t  gateTerms;
    int                         badCount  = 0;
    int                         checks    = 0;

    assign hready = hreadyout;

    initial forever #10 core_clk = ~core_clk;

    gate_term_select dut (
        .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sourcePins(pins),
        .dataInputs(dataInputs), .gateTerms(gateTerms)
    );

    function automatic logic gateOf(input logic [7:0] s, input logic [3:0] v);
        return |(s & {v[3], ~v[3], v[2], ~v[2], v[1], ~v[1], v[0], ~v[0]});
    endfunction : gateOf

    // other pins carry inverted copies so a wrong pick shows
    function automatic logic [63:0] pinsFor(input logic [3:0] p);
        logic [63:0] q;
        q = {16{~p}};
        for (int k = 0; k < 4; k++) q[PICK[k]] = p[k];
        return q;
    endfunction : pinsFor

    task automatic summarize();
        if (badCount == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rdVal = hrdata;
    endtask : busXfer

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        busXfer(1'b0, a, 32'h0000_0000);
        cmp(rdVal, e);
    endtask : rdChk

    task automatic setPins(input logic [3:0] p);
        @(posedge core_clk);
        pins <= pinsFor(p);
        repeat (4) @(posedge core_clk);
    endtask : setPins

    // the tests need about 1200 cycles; the margin only catches a stuck handshake
    initial begin
        #60000;
        badCount++;
        $display("Error at %0t: timeout", $time);
        summarize();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdChk(gate_term_pkg::ADDR_GATE2_TERM, {24'h0, gate_term_pkg::TERM_RESET});
        busXfer(1'b1, gate_term_pkg::ADDR_GATE2_TERM, 32'hFFFF_FFA5);
        busXfer(1'b1, gate_term_pkg::ADDR_GATE3_TERM, 32'h0000_005A);
        rdChk(gate_term_pkg::ADDR_GATE2_TERM, 32'h0000_00A5);
        rdChk(gate_term_pkg::ADDR_GATE3_TERM, 32'h0000_005A);
        busXfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdChk(8'h40, 32'h0000_0000);
        busXfer(1'b1, gate_term_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++) begin
            busXfer(1'b1, 8'(k * 4), {26'h0, PICK[k]});
            rdChk(8'(k * 4), {26'h0, PICK[k]});
        end
        for (int p = 0; p < 16; p++) begin
            setPins(4'(p));
            cmp({28'h0, dataInputs}, 32'(p));
            for (int i = 0; i < 8; i++) begin
                s2 = 8'h01 << i;
                s3 = 8'h80 >> i;
                busXfer(1'b1, gate_term_pkg::ADDR_GATE2_TERM, {24'h0, s2});
                busXfer(1'b1, gate_term_pkg::ADDR_GATE3_TERM, {24'h0, s3});
                repeat (2) @(posedge core_clk);
                cmp({30'h0, gateTerms}, {30'h0, gateOf(s3, 4'(p)), gateOf(s2, 4'(p))});
            end
        end
        // no term selected gives zero, both polarities give one
        busXfer(1'b1, gate_term_pkg::ADDR_GATE2_TERM, 32'h0000_0000);
        busXfer(1'b1, gate_term_pkg::ADDR_GATE3_TERM, 32'h0000_00C0);
        repeat (2) @(posedge core_clk);
        rdChk(gate_term_pkg::ADDR_STATUS, 32'h0000_002F);
        @(posedge core_clk);
        clkEn <= 1'b0;
        setPins(4'h3);
        repeat (2) @(posedge core_clk);
        cmp({28'h0, dataInputs}, 32'h0000_000F);
        clkEn <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp({28'h0, dataInputs}, 32'h0000_0003);
        summarize();
    end
endmodule : gate_term_select_tb_top

bind gate_term_select gate_term_select_props chk (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sourcePins(sourcePins),
    .dataInputs(dataInputs), .gateTerms(gateTerms)
);
